// [inc/crf_pkg.sv]
`default_nettype none
package crf_pkg;
	// ==========================================================
	// Sizes and register indices
	localparam int DATA_W = 16;
	localparam int REG_NUM = 16;
	localparam logic [3:0] PC_IDX = 4'h0;
	localparam logic [3:0] SP_IDX = 4'h1;
	localparam logic [3:0] SR_IDX = 4'h2;
	localparam logic [3:0] CG_IDX = 4'h3;
	localparam int GP_FIRST = 4;
	// ==========================================================
	// Status register fields
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_GIE = 3;
	localparam int SR_PROCESSOR_OFF_BIT = 4;
	localparam int SR_OSCILLATOR_OFF_BIT = 5;
	localparam int SR_GENERATOR_OFF_BIT = 6;
	localparam int SR_SUBSYSTEM_CLOCK_OFF_BIT = 7;
	localparam int SR_V = 8;
	localparam logic [15:0] SR_MASK = 16'h01FF;
	// ==========================================================
	// Reset values
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] SR_RESET = 16'h0000;
	localparam logic [15:0] GP_RESET = 16'h0000;
	// ==========================================================
	// Source modes and generated constants
	localparam logic [1:0] MODE_REG = 2'h0;
	localparam logic [1:0] MODE_IDX = 2'h1;
	localparam logic [1:0] MODE_IND = 2'h2;
	localparam logic [1:0] MODE_INC = 2'h3;
	localparam logic [15:0] CONST_ABS_BASE = 16'h0000;
	localparam logic [15:0] CONST_FOUR = 16'h0004;
	localparam logic [15:0] CONST_EIGHT = 16'h0008;
	localparam logic [15:0] CONST_ZERO = 16'h0000;
	localparam logic [15:0] CONST_ONE = 16'h0001;
	localparam logic [15:0] CONST_TWO = 16'h0002;
	localparam logic [15:0] CONST_ONES = 16'hFFFF;
	localparam logic [15:0] STACK_STEP = 16'h0002;
	localparam logic [15:0] WORD_BYTES = 16'h0002;
	localparam logic [15:0] EVEN_MASK = 16'hFFFE;
	localparam logic [15:0] LOW_MASK = 16'h00FF;
	// ==========================================================
	// Arithmetic operations
	typedef enum logic [2:0] {
		CRF_OP_ADD = 3'h0,
		CRF_OP_ADDC = 3'h1,
		CRF_OP_SUB = 3'h3,
		CRF_OP_SUBC = 3'h2,
		CRF_OP_CMP = 3'h6
	} crf_alu_op_e;
endpackage
`default_nettype wire

// [inc/crf_alu_if.sv]
`default_nettype none
interface crf_alu_if;
	crf_pkg::crf_alu_op_e op;
	logic byte_op;
	logic carry_in;
	logic [15:0] src;
	logic [15:0] dst;
	logic [15:0] res;
	logic c;
	logic z;
	logic n;
	logic v;
	modport calc (input op, byte_op, carry_in, src, dst, output res, c, z, n, v);
	modport user (output op, byte_op, carry_in, src, dst, input res, c, z, n, v);
endinterface
`default_nettype wire

// [src/crf_flag_calc.sv]
`default_nettype none
module crf_flag_calc (
	crf_alu_if.calc alu
);
	logic is_sub;
	logic cin;
	logic [15:0] opnd;
	logic [8:0] sum8;
	logic [16:0] sum16;
	logic sign_d;
	logic sign_s;

	// ==========================================================
	// Subtraction as dst plus inverted src plus carry
	always_comb begin
		is_sub = (alu.op == crf_pkg::CRF_OP_SUB) || (alu.op == crf_pkg::CRF_OP_SUBC) ||
			(alu.op == crf_pkg::CRF_OP_CMP);
		opnd = is_sub ? ~alu.src : alu.src;
		unique case (alu.op)
			crf_pkg::CRF_OP_ADDC, crf_pkg::CRF_OP_SUBC: cin = alu.carry_in;
			crf_pkg::CRF_OP_SUB, crf_pkg::CRF_OP_CMP: cin = 1'b1;
			default: cin = 1'b0;
		endcase
		sum8 = {1'b0, alu.dst[7:0]} + {1'b0, opnd[7:0]} + {8'h00, cin};
		sum16 = {1'b0, alu.dst} + {1'b0, opnd} + {16'h0000, cin};
		alu.res = alu.byte_op ? {8'h00, sum8[7:0]} : sum16[15:0];
		alu.n = alu.byte_op ? sum8[7] : sum16[15];
		alu.z = alu.byte_op ? (sum8[7:0] == 8'h00) : (sum16[15:0] == 16'h0000);
		alu.c = alu.byte_op ? sum8[8] : sum16[16];
		sign_d = alu.byte_op ? alu.dst[7] : alu.dst[15];
		sign_s = alu.byte_op ? opnd[7] : opnd[15];
		// Same-sign operands giving the other sign overflow
		alu.v = (sign_d == sign_s) && (alu.n != sign_d);
	end
endmodule // crf_flag_calc
`default_nettype wire

// [src/crf_regfile.sv]
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
module crf_regfile #(
	parameter int DATA_W = crf_pkg::DATA_W
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [3:0] rd_reg,
	input wire logic [1:0] source_mode_bits,
	input wire logic rd_byte,
	input wire logic rd_en,
	output var logic [15:0] rd_data_ff,
	output var logic rd_const_ff,
	input wire logic wr_en,
	input wire logic [3:0] wr_reg,
	input wire logic wr_byte,
	input wire logic [15:0] wr_data,
	input wire logic instr_done,
	input wire logic [1:0] instr_words,
	input wire logic push,
	input wire logic pop,
	output var logic [15:0] push_data_ff,
	input wire logic alu_go,
	input wire logic [2:0] alu_op,
	input wire logic alu_byte,
	input wire logic [3:0] alu_reg,
	input wire logic [15:0] alu_src,
	input wire logic [15:0] alu_dst,
	input wire logic dco_clock_in_use,
	input wire logic lfxt_clock_in_use,
	input wire logic irq_req,
	output var logic [15:0] program_counter_ff,
	output var logic [15:0] stack_pointer_ff,
	output var logic [15:0] status_register_ff,
	output var logic subsystem_clock_stop_ff,
	output var logic dco_generator_stop_ff,
	output var logic lfxt_osc_stop_ff,
	output var logic cpu_halt_ff,
	output var logic irq_take_ff
);
	// ==========================================================
	// Elaboration checks
	if (DATA_W != 16) begin : g_bad_width
		$error("crf_regfile serves only 16-bit data");
	end

	crf_alu_if alu ();
	logic [15:0] gp_ff [crf_pkg::GP_FIRST:crf_pkg::REG_NUM-1];
	logic [15:0] nxt_rd_data;
	logic nxt_rd_const;
	logic [15:0] nxt_pc;
	logic [15:0] nxt_sp;
	logic [15:0] nxt_sr;
	logic [15:0] alu_res_wr;
	logic alu_wr;

	// ==========================================================
	// Byte narrowing, shared by reads and writes
	function automatic logic [15:0] narrow(input logic [15:0] val, input logic is_byte);
		narrow = is_byte ? (val & crf_pkg::LOW_MASK) : val;
	endfunction

	// ==========================================================
	// Arithmetic and flags
	assign alu.op = crf_pkg::crf_alu_op_e'(alu_op);
	assign alu.byte_op = alu_byte;
	assign alu.carry_in = status_register_ff[crf_pkg::SR_C];
	assign alu.src = alu_src;
	assign alu.dst = alu_dst;
	assign alu_wr = alu_go && (alu.op != crf_pkg::CRF_OP_CMP);
	assign alu_res_wr = narrow(alu.res, alu_byte);

	crf_flag_calc u_flag_calc (
		.alu(alu.calc)
	);

	// ==========================================================
	// Operand read with constant generation
	always_comb begin
		nxt_rd_const = 1'b0;
		nxt_rd_data = 16'h0000;
		unique case (rd_reg)
			crf_pkg::PC_IDX: nxt_rd_data = narrow(program_counter_ff, rd_byte);
			crf_pkg::SP_IDX: nxt_rd_data = narrow(stack_pointer_ff, rd_byte);
			crf_pkg::SR_IDX: begin
				// Only register mode reaches the flags; other modes are constants
				nxt_rd_const = (source_mode_bits != crf_pkg::MODE_REG);
				unique case (source_mode_bits)
					crf_pkg::MODE_REG: nxt_rd_data = narrow(status_register_ff, rd_byte);
					crf_pkg::MODE_IDX: nxt_rd_data = crf_pkg::CONST_ABS_BASE;
					crf_pkg::MODE_IND: nxt_rd_data = crf_pkg::CONST_FOUR;
					crf_pkg::MODE_INC: nxt_rd_data = crf_pkg::CONST_EIGHT;
				endcase
			end
			crf_pkg::CG_IDX: begin
				nxt_rd_const = 1'b1;
				unique case (source_mode_bits)
					crf_pkg::MODE_REG: nxt_rd_data = crf_pkg::CONST_ZERO;
					crf_pkg::MODE_IDX: nxt_rd_data = crf_pkg::CONST_ONE;
					crf_pkg::MODE_IND: nxt_rd_data = crf_pkg::CONST_TWO;
					crf_pkg::MODE_INC: nxt_rd_data = narrow(crf_pkg::CONST_ONES, rd_byte);
				endcase
			end
			default: nxt_rd_data = narrow(gp_ff[rd_reg], rd_byte);
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rd_data_ff <= 16'h0000;
			rd_const_ff <= 1'b0;
		end else if (rd_en) begin
			rd_data_ff <= nxt_rd_data;
			rd_const_ff <= nxt_rd_const;
		end
	end

	// ==========================================================
	// Program counter
	always_comb begin
		nxt_pc = program_counter_ff;
		if (wr_en && wr_reg == crf_pkg::PC_IDX) begin
			nxt_pc = narrow(wr_data, wr_byte);
		end else if (alu_wr && alu_reg == crf_pkg::PC_IDX) begin
			nxt_pc = alu_res_wr;
		end else if (instr_done && !cpu_halt_ff && instr_words != 2'h0) begin
			// Length is whole words, so two, four or six bytes
			nxt_pc = program_counter_ff + crf_pkg::WORD_BYTES * {14'h0000, instr_words};
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			program_counter_ff <= crf_pkg::PC_RESET;
		end else begin
			program_counter_ff <= nxt_pc & crf_pkg::EVEN_MASK;
		end
	end

	// ==========================================================
	// Stack pointer
	always_comb begin
		nxt_sp = stack_pointer_ff;
		if (wr_en && wr_reg == crf_pkg::SP_IDX) begin
			// A pop into the pointer lands here and skips the increment
			nxt_sp = narrow(wr_data, wr_byte);
		end else if (alu_wr && alu_reg == crf_pkg::SP_IDX) begin
			nxt_sp = alu_res_wr;
		end else if (push) begin
			nxt_sp = stack_pointer_ff - crf_pkg::STACK_STEP;
		end else if (pop) begin
			nxt_sp = stack_pointer_ff + crf_pkg::STACK_STEP;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			stack_pointer_ff <= crf_pkg::SP_RESET;
		end else begin
			stack_pointer_ff <= nxt_sp & crf_pkg::EVEN_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			push_data_ff <= 16'h0000;
		end else if (push) begin
			push_data_ff <= stack_pointer_ff;
		end
	end

	// ==========================================================
	// Status register
	always_comb begin
		nxt_sr = status_register_ff;
		if (wr_en && wr_reg == crf_pkg::SR_IDX) begin
			nxt_sr = narrow(wr_data, wr_byte);
		end else if (alu_wr && alu_reg == crf_pkg::SR_IDX) begin
			nxt_sr = alu_res_wr;
		end else if (alu_go) begin
			nxt_sr[crf_pkg::SR_C] = alu.c;
			nxt_sr[crf_pkg::SR_Z] = alu.z;
			nxt_sr[crf_pkg::SR_N] = alu.n;
			nxt_sr[crf_pkg::SR_V] = alu.v;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			status_register_ff <= crf_pkg::SR_RESET;
		end else begin
			status_register_ff <= nxt_sr & crf_pkg::SR_MASK;
		end
	end

	// ==========================================================
	// Power and interrupt controls
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			subsystem_clock_stop_ff <= 1'b0;
			dco_generator_stop_ff <= 1'b0;
			lfxt_osc_stop_ff <= 1'b0;
			cpu_halt_ff <= 1'b0;
			irq_take_ff <= 1'b0;
		end else begin
			subsystem_clock_stop_ff <= nxt_sr[crf_pkg::SR_SUBSYSTEM_CLOCK_OFF_BIT];
			// An oscillator still feeding a clock must keep running
			dco_generator_stop_ff <= nxt_sr[crf_pkg::SR_GENERATOR_OFF_BIT] && !dco_clock_in_use;
			lfxt_osc_stop_ff <= nxt_sr[crf_pkg::SR_OSCILLATOR_OFF_BIT] && !lfxt_clock_in_use;
			cpu_halt_ff <= nxt_sr[crf_pkg::SR_PROCESSOR_OFF_BIT];
			irq_take_ff <= irq_req && status_register_ff[crf_pkg::SR_GIE];
		end
	end

	// ==========================================================
	// General-purpose registers; constant register three holds nothing
	for (genvar gi = crf_pkg::GP_FIRST; gi < crf_pkg::REG_NUM; gi++) begin : g_gp
		always_ff @(posedge mclk) begin
			if (!nrst) begin
				gp_ff[gi] <= crf_pkg::GP_RESET;
			end else if (wr_en && wr_reg == 4'(gi)) begin
				gp_ff[gi] <= narrow(wr_data, wr_byte);
			end else if (alu_wr && alu_reg == 4'(gi)) begin
				gp_ff[gi] <= alu_res_wr;
			end
		end
	end

	// ==========================================================
	// Check helpers; the add carry is rebuilt here rather than taken from the flag module
	logic sr_free;
	logic sp_free;
	logic [16:0] add_chk;
	assign sr_free = !(wr_en && wr_reg == crf_pkg::SR_IDX) && !(alu_wr && alu_reg == crf_pkg::SR_IDX);
	assign sp_free = !(wr_en && wr_reg == crf_pkg::SP_IDX) && !(alu_wr && alu_reg == crf_pkg::SP_IDX);
	assign add_chk = {1'b0, alu_src} + {1'b0, alu_dst};

	// ==========================================================
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence push_req_s;
		push && !(wr_en && wr_reg == crf_pkg::SP_IDX) && !(alu_wr && alu_reg == crf_pkg::SP_IDX);
	endsequence
	sequence push_done_s(logic [15:0] old);
		push_data_ff == old && stack_pointer_ff == ((old - crf_pkg::STACK_STEP) & crf_pkg::EVEN_MASK);
	endsequence
	sequence pop_req_s;
		pop && !push && sp_free;
	endsequence
	sequence pop_done_s(logic [15:0] old);
		stack_pointer_ff == ((old + crf_pkg::STACK_STEP) & crf_pkg::EVEN_MASK);
	endsequence
	sequence flag_upd_s;
		alu_go && sr_free;
	endsequence
	// Overflow is only cross-checked for word add and subtract; bytes rely on the bench
	sequence add_word_s;
		alu_go && sr_free && !alu_byte && alu.op == crf_pkg::CRF_OP_ADD;
	endsequence
	sequence sub_word_s;
		alu_go && sr_free && !alu_byte && alu.op == crf_pkg::CRF_OP_SUB;
	endsequence

	pc_even_a: assert property (program_counter_ff[0] == 1'b0) else $error("pc odd");
	sp_even_a: assert property (stack_pointer_ff[0] == 1'b0) else $error("sp odd");
	push_sp_a: assert property (push_req_s |=> push_done_s($past(stack_pointer_ff)))
		else $error("push of pointer wrong");
	pop_self_a: assert property (pop && wr_en && !wr_byte && wr_reg == crf_pkg::SP_IDX
		|=> stack_pointer_ff == ($past(wr_data) & crf_pkg::EVEN_MASK)) else $error("pop into pointer wrong");
	pc_step_a: assert property (instr_done && !cpu_halt_ff && instr_words != 2'h0 && !wr_en && !alu_go
		|=> program_counter_ff == $past(program_counter_ff) + {13'h0000, $past(instr_words), 1'b0})
		else $error("pc step wrong");
	halt_hold_a: assert property (cpu_halt_ff && !wr_en && !alu_go |=> $stable(program_counter_ff))
		else $error("pc moved while halted");
	const_ones_a: assert property (rd_en && rd_reg == crf_pkg::CG_IDX && source_mode_bits == crf_pkg::MODE_INC
		&& !rd_byte |=> rd_data_ff == crf_pkg::CONST_ONES && rd_const_ff) else $error("constant wrong");
	sr_reg_a: assert property (rd_en && rd_reg == crf_pkg::SR_IDX && source_mode_bits == crf_pkg::MODE_REG
		&& !rd_byte |=> !rd_const_ff && rd_data_ff == $past(status_register_ff)) else $error("flag read wrong");
	byte_read_a: assert property (rd_en && rd_byte |=> rd_data_ff[15:8] == 8'h00)
		else $error("byte read high set");
	irq_gate_a: assert property (irq_take_ff |-> $past(status_register_ff[crf_pkg::SR_GIE]) && $past(irq_req))
		else $error("interrupt passed while disabled");
	osc_keep_a: assert property (lfxt_osc_stop_ff |-> !$past(lfxt_clock_in_use))
		else $error("oscillator stopped in use");
	pop_step_a: assert property (pop_req_s |=> pop_done_s($past(stack_pointer_ff)))
		else $error("pop step wrong");
	pc_branch_a: assert property (wr_en && wr_reg == crf_pkg::PC_IDX && !wr_byte
		|=> program_counter_ff == ($past(wr_data) & crf_pkg::EVEN_MASK)) else $error("pc branch wrong");
	flag_zero_a: assert property (flag_upd_s
		|=> status_register_ff[crf_pkg::SR_Z] == ($past(alu_res_wr) == 16'h0000))
		else $error("zero flag wrong");
	flag_neg_a: assert property (flag_upd_s
		|=> status_register_ff[crf_pkg::SR_N] == $past(alu_byte ? alu_res_wr[7] : alu_res_wr[15]))
		else $error("negative flag wrong");
	add_carry_a: assert property (add_word_s |=> status_register_ff[crf_pkg::SR_C] == $past(add_chk[16]))
		else $error("add carry wrong");
	add_over_a: assert property (add_word_s |=> status_register_ff[crf_pkg::SR_V] ==
		$past((!alu_src[15] && !alu_dst[15] && alu_res_wr[15]) || (alu_src[15] && alu_dst[15] && !alu_res_wr[15])))
		else $error("add overflow wrong");
	sub_over_a: assert property (sub_word_s |=> status_register_ff[crf_pkg::SR_V] ==
		$past((!alu_dst[15] && alu_src[15] && alu_res_wr[15]) || (alu_dst[15] && !alu_src[15] && !alu_res_wr[15])))
		else $error("subtract overflow wrong");
	sclk_stop_a: assert property (subsystem_clock_stop_ff == status_register_ff[crf_pkg::SR_SUBSYSTEM_CLOCK_OFF_BIT])
		else $error("subsystem clock stop wrong");
	cpu_stop_a: assert property (cpu_halt_ff == status_register_ff[crf_pkg::SR_PROCESSOR_OFF_BIT])
		else $error("halt level wrong");
	dco_keep_a: assert property (dco_generator_stop_ff
		|-> status_register_ff[crf_pkg::SR_GENERATOR_OFF_BIT] && !$past(dco_clock_in_use))
		else $error("generator stopped in use");
	osc_bit_a: assert property (lfxt_osc_stop_ff |-> status_register_ff[crf_pkg::SR_OSCILLATOR_OFF_BIT])
		else $error("oscillator stop without bit");
	irq_pass_a: assert property (irq_req && status_register_ff[crf_pkg::SR_GIE] |=> irq_take_ff)
		else $error("enabled interrupt not passed");
	const_src_a: assert property (rd_en && rd_reg == crf_pkg::CG_IDX |=> rd_const_ff)
		else $error("constant register not source only");
	const_four_a: assert property (rd_en && rd_reg == crf_pkg::SR_IDX
		&& source_mode_bits == crf_pkg::MODE_IND |=> rd_data_ff == crf_pkg::CONST_FOUR && rd_const_ff)
		else $error("constant four wrong");
	const_byte_a: assert property (rd_en && rd_byte && rd_reg == crf_pkg::CG_IDX
		&& source_mode_bits == crf_pkg::MODE_INC |=> rd_data_ff == 16'h00FF) else $error("byte constant wrong");
	byte_write_a: assert property (wr_en && wr_byte && wr_reg >= 4'(crf_pkg::GP_FIRST)
		|=> gp_ff[$past(wr_reg)][15:8] == 8'h00) else $error("byte write kept high byte");
endmodule // crf_regfile
`default_nettype wire

// [testbench/crf_stack_model.sv]
`default_nettype none
// ==========================================================
// Far-side stack memory, word addressed
module crf_stack_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic push,
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] push_data,
	output logic [15:0] top_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic push_seen_ff;
	// Store waits one cycle so the pointer has already moved down
	always_ff @(posedge mclk) begin
		push_seen_ff <= nrst & push;
		if (push_seen_ff) begin
			mem[stack_pointer[8:1]] <= push_data;
		end
	end
	// Bit 0 dropped: only even stack addresses exist here
	assign top_word = mem[stack_pointer[8:1]];
endmodule // crf_stack_model
`default_nettype wire

// [testbench/cpu_register_file_with_constgen_bench.sv]
`default_nettype none
module cpu_register_file_with_constgen_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] op;
		logic b;
		logic [15:0] src, dst, res, sr;
	} crf_alu_case_s;
	localparam logic [15:0] R2C [4] = '{16'h0000, 16'h0000, 16'h0004, 16'h0008};
	localparam logic [15:0] R3C [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
	localparam crf_alu_case_s ALU_TAB [7] = '{
		'{crf_pkg::CRF_OP_ADD, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 16'h0104},
		'{crf_pkg::CRF_OP_ADD, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0003},
		'{crf_pkg::CRF_OP_ADDC, 1'b0, 16'h0000, 16'h0000, 16'h0001, 16'h0000},
		'{crf_pkg::CRF_OP_SUB, 1'b0, 16'h0001, 16'h8000, 16'h7FFF, 16'h0101},
		'{crf_pkg::CRF_OP_SUBC, 1'b0, 16'h0001, 16'h0000, 16'hFFFF, 16'h0004},
		'{crf_pkg::CRF_OP_CMP, 1'b0, 16'h0001, 16'h0001, 16'hFFFF, 16'h0003},
		'{crf_pkg::CRF_OP_ADD, 1'b1, 16'h007F, 16'h3301, 16'h0080, 16'h0104}};
	logic mclk, nrst, rd_byte, rd_en, wr_en, wr_byte, instr_done, push, pop, alu_go, alu_byte;
	logic [3:0] rd_reg, wr_reg, alu_reg;
	logic [1:0] source_mode_bits, instr_words;
	logic [15:0] wr_data, alu_src, alu_dst, rd_data_ff, push_data_ff, top_word;
	logic [15:0] program_counter_ff, stack_pointer_ff, status_register_ff;
	logic [2:0] alu_op;
	logic dco_clock_in_use, lfxt_clock_in_use, irq_req, rd_const_ff;
	logic subsystem_clock_stop_ff, dco_generator_stop_ff, lfxt_osc_stop_ff, cpu_halt_ff, irq_take_ff;
	logic [15:0] pw;
	int errors, compares, cycles;
	crf_regfile crf_regfile_inst (
		.mclk(mclk), .nrst(nrst), .rd_reg(rd_reg), .source_mode_bits(source_mode_bits), .rd_byte(rd_byte),
		.rd_en(rd_en), .rd_data_ff(rd_data_ff), .rd_const_ff(rd_const_ff), .wr_en(wr_en), .wr_reg(wr_reg),
		.wr_byte(wr_byte), .wr_data(wr_data), .instr_done(instr_done), .instr_words(instr_words),
		.push(push), .pop(pop), .push_data_ff(push_data_ff), .alu_go(alu_go), .alu_op(alu_op),
		.alu_byte(alu_byte), .alu_reg(alu_reg), .alu_src(alu_src), .alu_dst(alu_dst),
		.dco_clock_in_use(dco_clock_in_use), .lfxt_clock_in_use(lfxt_clock_in_use), .irq_req(irq_req),
		.program_counter_ff(program_counter_ff), .stack_pointer_ff(stack_pointer_ff),
		.status_register_ff(status_register_ff), .subsystem_clock_stop_ff(subsystem_clock_stop_ff),
		.dco_generator_stop_ff(dco_generator_stop_ff), .lfxt_osc_stop_ff(lfxt_osc_stop_ff),
		.cpu_halt_ff(cpu_halt_ff), .irq_take_ff(irq_take_ff));
	crf_stack_model crf_stack_model_inst (.mclk(mclk), .nrst(nrst), .push(push),
		.stack_pointer(stack_pointer_ff), .push_data(push_data_ff), .top_word(top_word));
	assign pw = {11'h000, subsystem_clock_stop_ff, dco_generator_stop_ff, lfxt_osc_stop_ff, cpu_halt_ff, irq_take_ff};
	// ==========================================================
	// Access tasks
	task automatic report_and_stop;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t ns: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Strobes drop one edge after rising, so every call leaves a gap cycle
	task automatic done_op;
		@(posedge mclk);
		{rd_en, wr_en, instr_done, push, pop, alu_go} <= 6'h00;
		#1;
	endtask
	task automatic wr(input logic [3:0] r, input logic [15:0] d, input logic b);
		@(posedge mclk);
		wr_en <= 1'b1;
		wr_reg <= r;
		wr_data <= d;
		wr_byte <= b;
		done_op();
	endtask
	task automatic rd(input logic [3:0] r, input logic [1:0] m, input logic b, input logic [15:0] exp,
		input logic c);
		@(posedge mclk);
		rd_en <= 1'b1;
		rd_reg <= r;
		source_mode_bits <= m;
		rd_byte <= b;
		done_op();
		chk({rd_const_ff, rd_data_ff}, {c, exp}, "read data");
	endtask
	task automatic step(input logic [1:0] w);
		@(posedge mclk);
		instr_done <= 1'b1;
		instr_words <= w;
		done_op();
	endtask
	task automatic stack_op(input logic ps, input logic pp, input logic sp_wr);
		repeat (2) @(posedge mclk);
		push <= ps;
		pop <= pp;
		wr_en <= sp_wr;
		wr_reg <= crf_pkg::SP_IDX;
		wr_data <= top_word;
		wr_byte <= 1'b0;
		done_op();
	endtask
	task automatic alu(input crf_alu_case_s t);
		@(posedge mclk);
		alu_go <= 1'b1;
		alu_op <= t.op;
		alu_byte <= t.b;
		alu_src <= t.src;
		alu_dst <= t.dst;
		alu_reg <= 4'h5;
		done_op();
	endtask
	// ==========================================================
	// Clock, timeout and test sequence
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		{nrst, rd_en, wr_en, instr_done, push, pop, alu_go, rd_byte, wr_byte, alu_byte} = 10'h000;
		{rd_reg, wr_reg, alu_reg, source_mode_bits, instr_words, alu_op} = 19'h00000;
		{wr_data, alu_src, alu_dst} = 48'h0;
		{dco_clock_in_use, lfxt_clock_in_use, irq_req} = 3'h7;
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		chk(program_counter_ff, 16'h0000, "pc reset");
		chk(stack_pointer_ff, 16'h0000, "sp reset");
		chk(status_register_ff, 16'h0000, "sr reset");
		for (int m = 1; m < 4; m++) rd(4'h2, m[1:0], 1'b0, R2C[m], 1'b1);
		for (int m = 0; m < 4; m++) rd(4'h3, m[1:0], 1'b0, R3C[m], 1'b1);
		rd(4'h3, 2'h3, 1'b1, 16'h00FF, 1'b1);
		wr(4'h3, 16'h5A5A, 1'b0);
		rd(4'h3, 2'h0, 1'b0, 16'h0000, 1'b1);
		wr(4'h2, 16'h0001, 1'b0);
		rd(4'h2, 2'h0, 1'b0, 16'h0001, 1'b0);
		rd(4'h2, 2'h1, 1'b0, 16'h0000, 1'b1);
		wr(4'h2, 16'h0000, 1'b0);
		for (int r = 4; r < 16; r++) wr(r[3:0], {r[3:0], 4'hA, r[3:0], 4'h5}, 1'b0);
		for (int r = 4; r < 16; r++) rd(r[3:0], 2'h0, 1'b0, {r[3:0], 4'hA, r[3:0], 4'h5}, 1'b0);
		rd(4'hF, 2'h0, 1'b1, 16'h00F5, 1'b0);
		wr(4'h4, 16'h12C3, 1'b1);
		rd(4'h4, 2'h0, 1'b0, 16'h00C3, 1'b0);
		wr(4'h0, 16'h1235, 1'b0);
		chk(program_counter_ff, 16'h1234, "pc branch");
		step(2'h1);
		chk(program_counter_ff, 16'h1236, "pc +2");
		step(2'h2);
		chk(program_counter_ff, 16'h123A, "pc +4");
		step(2'h3);
		chk(program_counter_ff, 16'h1240, "pc +6");
		step(2'h0);
		chk(program_counter_ff, 16'h1240, "pc no step");
		wr(4'h1, 16'h0201, 1'b0);
		chk(stack_pointer_ff, 16'h0200, "sp even");
		stack_op(1'b1, 1'b0, 1'b0);
		chk(stack_pointer_ff, 16'h01FE, "sp predecrement");
		chk(push_data_ff, 16'h0200, "pushed sp");
		stack_op(1'b0, 1'b1, 1'b1);
		chk(stack_pointer_ff, 16'h0200, "pop into sp");
		stack_op(1'b0, 1'b1, 1'b0);
		chk(stack_pointer_ff, 16'h0202, "sp postincrement");
		foreach (ALU_TAB[i]) begin
			alu(ALU_TAB[i]);
			chk(status_register_ff, ALU_TAB[i].sr, "flags");
			rd(4'h5, 2'h0, 1'b0, ALU_TAB[i].res, 1'b0);
		end
		// Oscillators in use: their stop bits must not take effect
		wr(4'h2, 16'h00F0, 1'b0);
		step(2'h1);
		chk(program_counter_ff, 16'h1240, "halted pc");
		chk(pw, 16'h0012, "power, oscillators busy");
		@(posedge mclk);
		dco_clock_in_use <= 1'b0;
		lfxt_clock_in_use <= 1'b0;
		wr(4'h2, 16'hFEF8, 1'b0);
		chk(status_register_ff, 16'h00F8, "sr upper bits");
		@(posedge mclk);
		#1;
		chk(pw, 16'h001F, "power, oscillators idle");
		wr(4'h2, 16'h0000, 1'b0);
		@(posedge mclk);
		#1;
		chk(pw, 16'h0000, "power released");
		report_and_stop();
	end
endmodule // cpu_register_file_with_constgen_bench
`default_nettype wire
